/* rtl/lcd_pixel_path.sv */
// lcd pixel datapath: palette lookup, dither, formatter, fifo, panel drive
//
// Functional notes
// - TFT: palette RGB straight to outputs
// - STN: dither each 4-bit gun to one bit
// - mono panels use only the blue gun
// - pack 4/8 mono or 2 2/3 color pixels
// - color STN buffered in fifo, constant drain
// - accept 8 or 16 bit logical pixels
// - 8bpp: all palettes indexed by pixel[7:0]
// - 16bpp: red 15:8, green 11:4, blue 7:0
// - TFT palettes 256 x 5/6/5 bits
// - STN palettes 256 x 4 bits
// - 15 levels, top two codes identical
// - upper codes on-fractions as tabulated
// - lower codes on-fractions as tabulated
// - color STN dithers three guns alike
// - earliest mono pixels on low lines
`timescale 1ns/1ps
`default_nettype none
module lcd_pixel_path
	import lcd_path_pkg::*;
(
	input wire logic core_clk, // 100 MHz core clock
	input wire logic resetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic pix_valid, // logical pixel offered
	input wire logic [15:0] pix_data, // logical pixel value
	output logic pix_ready, // pixel taken when valid too
	input wire logic line_start, // pulse, first pixel of a line follows
	input wire logic frame_start, // pulse, first pixel of a frame follows
	output logic [4:0] tft_red, // tft red
	output logic [5:0] tft_green, // tft green
	output logic [4:0] tft_blue, // tft blue
	output logic tft_valid, // tft pixel strobe
	output logic [7:0] panel_data_pins, // stn panel data
	output logic panel_strobe // stn word strobe, one cycle
);
	typedef struct packed {
		logic [CTRL_WIDTH-1:0] ctrl;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic pix_ready;
		logic s1_valid;
		logic [4:0] s1_red;
		logic [5:0] s1_green;
		logic [4:0] s1_blue;
		logic [3:0] x9;
		logic [3:0] x5;
		logic [3:0] x15;
		logic [3:0] x2;
		logic [3:0] f9;
		logic [3:0] f5;
		logic [3:0] f15;
		logic [3:0] f2;
		logic [10:0] acc;
		logic [3:0] cnt;
		logic push_valid;
		logic [7:0] push_data;
		logic [4:0] tft_red;
		logic [5:0] tft_green;
		logic [4:0] tft_blue;
		logic tft_valid;
		logic [3:0] div;
		logic [7:0] panel_data;
		logic panel_strobe;
	} path_state_type;

	path_state_type state_reg;
	path_state_type state_next;

	// palette arrays, one per gun
	logic [4:0] pal_red [PAL_ENTRIES];
	logic [5:0] pal_green [PAL_ENTRIES];
	logic [4:0] pal_blue [PAL_ENTRIES];

	logic en;
	logic bpp16;
	logic mono;
	logic tft;
	logic mono8;
	logic [7:0] idx_red;
	logic [7:0] idx_green;
	logic [7:0] idx_blue;
	logic [7:0] apb_idx;
	logic is_pal;
	logic pal_write;
	logic take;
	logic [3:0] p9;
	logic [3:0] p5;
	logic [3:0] p15;
	logic [3:0] p2;
	logic [3:0] gun_level [3];
	logic [2:0] gun_on;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic fifo_out_ready;
	logic [3:0] fifo_level;

	// ==========================================================
	// control decode
	assign en = state_reg.ctrl[CTRL_EN_BIT];
	assign bpp16 = state_reg.ctrl[CTRL_BPP16_BIT];
	assign mono = state_reg.ctrl[CTRL_MONO_BIT];
	assign tft = state_reg.ctrl[CTRL_TFT_BIT];
	assign mono8 = state_reg.ctrl[CTRL_MONO8_BIT];

	// palette indexes per bits-per-pixel
	assign idx_red = bpp16 ? pix_data[15:8] : pix_data[7:0];
	assign idx_green = bpp16 ? pix_data[11:4] : pix_data[7:0];
	assign idx_blue = pix_data[7:0];
	assign take = pix_valid && state_reg.pix_ready;

	// apb decode
	assign apb_idx = paddr[9:2];
	assign is_pal = (paddr[11:10] == PAL_SELECT);
	assign pal_write = psel && penable && pwrite && state_reg.pready && is_pal;

	// ==========================================================
	// dither phases: pixel position plus frame count
	function automatic logic [3:0] add_mod(input logic [3:0] a, input logic [3:0] b,
		input logic [3:0] n);
		logic [4:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, n})
			s = s - {1'b0, n};
		return s[3:0];
	endfunction

	function automatic logic [3:0] inc_mod(input logic [3:0] a, input logic [3:0] n);
		return (a == n - 4'h1) ? 4'h0 : a + 4'h1;
	endfunction

	assign p9 = add_mod(state_reg.x9, state_reg.f9, PERIOD_9);
	assign p5 = add_mod(state_reg.x5, state_reg.f5, PERIOD_5);
	assign p15 = add_mod(state_reg.x15, state_reg.f15, PERIOD_15);
	assign p2 = add_mod(state_reg.x2, state_reg.f2, PERIOD_2);

	// low four bits of each gun feed the dither
	assign gun_level[0] = state_reg.s1_red[3:0];
	assign gun_level[1] = state_reg.s1_green[3:0];
	assign gun_level[2] = state_reg.s1_blue[3:0];

	// three identical dither units, one per gun
	generate
		for (genvar g = 0; g < 3; g++)
		begin : gun
			gun_dither u_dither (
				.level(gun_level[g]),
				.phase9(p9),
				.phase5(p5),
				.phase15(p15),
				.phase2(p2),
				.pixel_on(gun_on[g])
			);
		end
	endgenerate

	// ==========================================================
	// constant rate drain of the fifo
	assign fifo_out_ready = (state_reg.div == 4'h0);

	word_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_valid(state_reg.push_valid),
		.in_data(state_reg.push_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_out_ready),
		.level(fifo_level)
	);

	// ==========================================================
	// next state of the whole path
	always_comb
	begin
		logic [10:0] tmp;
		logic [3:0] ncnt;
		logic [3:0] wbits;
		logic [2:0] bits;
		logic [7:0] word;
		tmp = '0;
		ncnt = '0;
		wbits = '0;
		bits = '0;
		word = '0;
		state_next = state_reg;

		// apb: answer one cycle after setup, zero wait in access
		state_next.pready = psel && !penable;
		state_next.pslverr = 1'b0;
		if (psel && !penable)
		begin
			state_next.prdata = UNMAPPED_READ;
			if (is_pal)
				state_next.prdata = {16'h0000, pal_blue[apb_idx], pal_green[apb_idx],
					pal_red[apb_idx]};
			else if (paddr == CTRL_OFFSET)
				state_next.prdata = {27'h0, state_reg.ctrl};
			else if (paddr == STATUS_OFFSET)
				state_next.prdata = {26'h0, fifo_out_valid, fifo_in_ready, fifo_level};
			else
				state_next.pslverr = 1'b1;
		end
		if (psel && penable && pwrite && state_reg.pready && paddr == CTRL_OFFSET)
			state_next.ctrl = pwdata[CTRL_WIDTH-1:0];

		// stage 1: palette lookup of the taken pixel
		state_next.s1_valid = take;
		if (take)
		begin
			state_next.s1_red = pal_red[idx_red];
			state_next.s1_green = pal_green[idx_green];
			state_next.s1_blue = pal_blue[idx_blue];
		end

		// stage 2: tft bypass or dither and format
		state_next.tft_valid = 1'b0;
		state_next.push_valid = 1'b0;
		if (state_reg.s1_valid && tft)
		begin
			state_next.tft_red = state_reg.s1_red;
			state_next.tft_green = state_reg.s1_green;
			state_next.tft_blue = state_reg.s1_blue;
			state_next.tft_valid = 1'b1;
		end
		else if (state_reg.s1_valid)
		begin
			// advance the pixel position phases
			state_next.x9 = inc_mod(state_reg.x9, PERIOD_9);
			state_next.x5 = inc_mod(state_reg.x5, PERIOD_5);
			state_next.x15 = inc_mod(state_reg.x15, PERIOD_15);
			state_next.x2 = inc_mod(state_reg.x2, PERIOD_2);
			// mono takes blue only, color appends r, g, b
			if (mono)
			begin
				bits = {2'b00, gun_on[2]};
				ncnt = state_reg.cnt + 4'h1;
			end
			else
			begin
				bits = {gun_on[2], gun_on[1], gun_on[0]};
				ncnt = state_reg.cnt + 4'h3;
			end
			wbits = (mono && !mono8) ? WORD_BITS_NARROW : WORD_BITS_WIDE;
			tmp = state_reg.acc | ({8'h00, bits} << state_reg.cnt);
			if (ncnt >= wbits)
			begin
				if (!mono)
				begin
					// first pixel's red on the top line
					for (int i = 0; i < 8; i++)
						word[7 - i] = tmp[i];
				end
				else if (mono8)
					word = tmp[7:0];
				else
					word = {4'h0, tmp[3:0]};
				state_next.push_valid = 1'b1;
				state_next.push_data = word;
				tmp = tmp >> wbits;
				ncnt = ncnt - wbits;
			end
			state_next.acc = tmp;
			state_next.cnt = ncnt;
		end

		// line and frame restart the position phases
		if (line_start || frame_start)
		begin
			state_next.x9 = 4'h0;
			state_next.x5 = 4'h0;
			state_next.x15 = 4'h0;
			state_next.x2 = 4'h0;
		end
		if (frame_start)
		begin
			state_next.f9 = inc_mod(state_reg.f9, PERIOD_9);
			state_next.f5 = inc_mod(state_reg.f5, PERIOD_5);
			state_next.f15 = inc_mod(state_reg.f15, PERIOD_15);
			state_next.f2 = inc_mod(state_reg.f2, PERIOD_2);
			state_next.acc = '0;
			state_next.cnt = '0;
		end

		// disabled path drops partial words
		if (!en)
		begin
			state_next.s1_valid = 1'b0;
			state_next.acc = '0;
			state_next.cnt = '0;
		end

		// room for every in-flight pixel keeps the fifo from overflow
		state_next.pix_ready = en && (tft || fifo_level <= FIFO_FILL_LIMIT);

		// drain divider and panel word register
		state_next.div = (state_reg.div == 4'h0) ? DRAIN_DIV - 4'h1 : state_reg.div - 4'h1;
		state_next.panel_strobe = 1'b0;
		if (fifo_out_ready && fifo_out_valid)
		begin
			state_next.panel_data = fifo_out_data;
			state_next.panel_strobe = 1'b1;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= '0;
			state_reg.ctrl <= CTRL_RESET;
		end
		else
			state_reg <= state_next;
	end

	// palette write from apb, each gun its own field
	always_ff @(posedge core_clk)
	begin
		if (pal_write)
		begin
			pal_red[apb_idx] <= pwdata[PAL_RED_LSB +: 5];
			pal_green[apb_idx] <= pwdata[PAL_GREEN_LSB +: 6];
			pal_blue[apb_idx] <= pwdata[PAL_BLUE_LSB +: 5];
		end
	end

	// ==========================================================
	// outputs straight from the state register
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign pix_ready = state_reg.pix_ready;
	assign tft_red = state_reg.tft_red;
	assign tft_green = state_reg.tft_green;
	assign tft_blue = state_reg.tft_blue;
	assign tft_valid = state_reg.tft_valid;
	assign panel_data_pins = state_reg.panel_data;
	assign panel_strobe = state_reg.panel_strobe;
endmodule
`default_nettype wire

/* rtl/lcd_path_pkg.sv */
// shared constants for the lcd pixel palette and dither path
package lcd_path_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [1:0] PAL_SELECT = 2'h1; // paddr[11:10] for 0x400..0x7fc
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ==========================================================
	// control register fields and reset value
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_BPP16_BIT = 1;
	localparam int CTRL_MONO_BIT = 2;
	localparam int CTRL_TFT_BIT = 3;
	localparam int CTRL_MONO8_BIT = 4;
	localparam int CTRL_WIDTH = 5;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	// ==========================================================
	// status register fields
	localparam int STATUS_LEVEL_LSB = 0;
	localparam int STATUS_IN_READY_BIT = 4;
	localparam int STATUS_OUT_VALID_BIT = 5;

	// ==========================================================
	// palette word layout: red 5, green 6, blue 5
	localparam int PAL_RED_LSB = 0;
	localparam int PAL_GREEN_LSB = 5;
	localparam int PAL_BLUE_LSB = 11;
	localparam int PAL_ENTRIES = 256;

	// ==========================================================
	// formatter, fifo and drain timing
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] FIFO_FILL_LIMIT = 4'h4; // accept pixels while level <= this
	localparam logic [3:0] WORD_BITS_WIDE = 4'h8;
	localparam logic [3:0] WORD_BITS_NARROW = 4'h4;
	localparam logic [3:0] DRAIN_DIV = 4'h4; // core clocks per panel word

	// ==========================================================
	// dither modulation periods
	localparam logic [3:0] PERIOD_9 = 4'h9;
	localparam logic [3:0] PERIOD_5 = 4'h5;
	localparam logic [3:0] PERIOD_15 = 4'hf;
	localparam logic [3:0] PERIOD_2 = 4'h2;
endpackage

/* rtl/gun_dither.sv */
// one gun of the time/space dither: 4-bit level to one on/off bit
`timescale 1ns/1ps
`default_nettype none
module gun_dither
	import lcd_path_pkg::*;
(
	input wire logic [3:0] level, // palette code for this gun
	input wire logic [3:0] phase9, // position mod 9
	input wire logic [3:0] phase5, // position mod 5
	input wire logic [3:0] phase15, // position mod 15
	input wire logic [3:0] phase2, // position mod 2
	output logic pixel_on // dithered bit, high is on
);
	// ==========================================================
	// on-fraction per code, 15 distinct levels
	always_comb
	begin
		unique case (level)
			4'hf: pixel_on = 1'b1;
			4'he: pixel_on = 1'b1;
			4'hd: pixel_on = (phase9 < 4'h8);
			4'hc: pixel_on = (phase5 < 4'h4);
			4'hb: pixel_on = (phase15 < 4'hb);
			4'ha: pixel_on = (phase9 < 4'h6);
			4'h9: pixel_on = (phase5 < 4'h3);
			4'h8: pixel_on = (phase9 < 4'h5);
			4'h7: pixel_on = (phase2 < 4'h1);
			4'h6: pixel_on = (phase9 < 4'h4);
			4'h5: pixel_on = (phase5 < 4'h2);
			4'h4: pixel_on = (phase9 < 4'h3);
			4'h3: pixel_on = (phase15 < 4'h4);
			4'h2: pixel_on = (phase5 < 4'h1);
			4'h1: pixel_on = (phase9 < 4'h1);
			4'h0: pixel_on = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* rtl/word_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic in_valid, // write request
	input wire logic [WIDTH-1:0] in_data, // write word
	output logic in_ready, // room for a word
	output logic out_valid, // word available
	output logic [WIDTH-1:0] out_data, // head word
	input wire logic out_ready, // read request
	output logic [$clog2(DEPTH+1)-1:0] level // words held
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} fifo_state_type;

	fifo_state_type state_reg;
	fifo_state_type state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic wr_en;
	logic rd_en;

	// ==========================================================
	// handshake and flags
	assign in_ready = (state_reg.count != CW'(DEPTH));
	assign out_valid = (state_reg.count != '0);
	assign out_data = mem[state_reg.rd_ptr];
	assign level = state_reg.count;
	assign wr_en = in_valid && in_ready;
	assign rd_en = out_valid && out_ready;

	// pointer and count update
	always_comb
	begin
		state_next = state_reg;
		if (wr_en)
			state_next.wr_ptr = (state_reg.wr_ptr == PW'(DEPTH-1)) ? '0 : state_reg.wr_ptr + 1'b1;
		if (rd_en)
			state_next.rd_ptr = (state_reg.rd_ptr == PW'(DEPTH-1)) ? '0 : state_reg.rd_ptr + 1'b1;
		if (wr_en && !rd_en)
			state_next.count = state_reg.count + 1'b1;
		else if (rd_en && !wr_en)
			state_next.count = state_reg.count - 1'b1;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	// storage, no reset needed
	always_ff @(posedge core_clk)
	begin
		if (wr_en)
			mem[state_reg.wr_ptr] <= in_data;
	end
endmodule
`default_nettype wire

/* sim/lcd_pixel_path_properties.sv */
// port checker for the lcd pixel path
`timescale 1ns/1ps
`default_nettype none
module lcd_pixel_path_checker
	import lcd_path_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic resetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic pix_valid, // pixel offer
	input wire logic pix_ready, // pixel taken
	input wire logic tft_valid, // tft strobe
	input wire logic [4:0] tft_red, // tft red
	input wire logic [7:0] panel_data_pins, // stn word
	input wire logic panel_strobe // stn strobe
);
	// ====
	// shadow of the control word
	logic [4:0] ctrl_reg;
	logic [4:0] ctrl_next;
	logic take;
	logic map_ok;
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (psel && penable && pready && pwrite && paddr == CTRL_OFFSET)
		begin
			ctrl_next = pwdata[4:0];
		end
	end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_reg <= CTRL_RESET;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
		end
	end
	// pixel handshake and address decode
	assign take = pix_valid && pix_ready;
	assign map_ok = paddr == CTRL_OFFSET || paddr == STATUS_OFFSET || paddr[11:10] == PAL_SELECT;
	// ====
	// properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		take;
	endsequence
	sequence s_tft_out;
		##2 tft_valid;
	endsequence
	property p_tft_lat;
		ctrl_reg[3] ##0 s_take |-> s_tft_out;
	endproperty
	a_tft_lat: assert property (p_tft_lat) else $error("tft pixel late");
	property p_tft_cause;
		tft_valid |-> $past(take, 2);
	endproperty
	a_tft_cause: assert property (p_tft_cause) else $error("tft strobe uncaused");
	property p_stn_silent;
		tft_valid |-> ctrl_reg[3];
	endproperty
	a_stn_silent: assert property (p_stn_silent) else $error("tft strobe in stn");
	property p_tft_hold;
		!tft_valid |-> $stable(tft_red);
	endproperty
	a_tft_hold: assert property (p_tft_hold) else $error("tft moved");
	property p_strobe_gap;
		panel_strobe |=> !panel_strobe [*3];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("drain too fast");
	property p_pins_hold;
		!panel_strobe |-> $stable(panel_data_pins);
	endproperty
	a_pins_hold: assert property (p_pins_hold) else $error("pins moved");
	property p_mono4_top;
		panel_strobe && ctrl_reg[2] && !ctrl_reg[4] |-> panel_data_pins[7:4] == 4'h0;
	endproperty
	a_mono4_top: assert property (p_mono4_top) else $error("mono4 top set");
	property p_ready_off;
		!ctrl_reg[0] && !$past(ctrl_reg[0]) |-> !pix_ready;
	endproperty
	a_ready_off: assert property (p_ready_off) else $error("ready while off");
	property p_pready;
		psel && !penable |=> pready;
	endproperty
	a_pready: assert property (p_pready) else $error("no ready");
	property p_err;
		pready |-> pslverr == !map_ok;
	endproperty
	a_err: assert property (p_err) else $error("bad error flag");
endmodule
`default_nettype wire

/* sim/panel_model.sv */
// passive panel: collects stn words and tft pixels
`timescale 1ns/1ps
`default_nettype none
module panel_model (
	input wire logic core_clk, // clock
	input wire logic [4:0] tft_red, // red
	input wire logic [5:0] tft_green, // green
	input wire logic [4:0] tft_blue, // blue
	input wire logic tft_valid, // tft strobe
	input wire logic [7:0] panel_data_pins, // stn word
	input wire logic panel_strobe // stn strobe
);
	logic [7:0] words[$];
	logic [15:0] pixels[$];
	// latch per strobe, a high bit lights a pixel
	always @(posedge core_clk)
	begin
		if (panel_strobe === 1'b1)
			words.push_back(panel_data_pins);
		if (tft_valid === 1'b1)
			pixels.push_back({tft_blue, tft_green, tft_red});
	end
endmodule
`default_nettype wire

/* sim/test_lcd_pixel_path.sv */
// testbench for the lcd pixel path
`timescale 1ns/1ps
`default_nettype none
module test_lcd_pixel_path;
	import lcd_path_pkg::*;
	logic core_clk, resetn, psel, penable, pwrite, pix_valid, line_start, frame_start;
	logic pready, pslverr, pix_ready, tft_valid, panel_strobe, er, seen_stall;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pix_data;
	logic [4:0] tft_red, tft_blue;
	logic [5:0] tft_green;
	logic [7:0] panel_data_pins;
	int err_total = 0;
	int total_checks = 0;
	lcd_pixel_path u_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid),
		.pix_data(pix_data), .pix_ready(pix_ready), .line_start(line_start),
		.frame_start(frame_start), .tft_red(tft_red), .tft_green(tft_green),
		.tft_blue(tft_blue), .tft_valid(tft_valid), .panel_data_pins(panel_data_pins),
		.panel_strobe(panel_strobe));
	panel_model u_panel (.core_clk(core_clk), .tft_red(tft_red), .tft_green(tft_green),
		.tft_blue(tft_blue), .tft_valid(tft_valid), .panel_data_pins(panel_data_pins),
		.panel_strobe(panel_strobe));
	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// ====
	// common tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never re-drives psel in this step
		@(posedge core_clk);
	endtask
	task automatic palw(input logic [7:0] i, input logic [15:0] v);
		apb(1'b1, 12'h400 + {i, 2'b00}, {16'h0, v});
	endtask
	task automatic px(input logic [15:0] d);
		pix_valid <= 1'b1;
		pix_data <= d;
		do
		begin
			@(posedge core_clk);
			if (pix_ready !== 1'b1)
				seen_stall = 1'b1;
		end
		while (pix_ready !== 1'b1);
	endtask
	task automatic pulse(input logic ln);
		if (ln)
			line_start <= 1'b1;
		else
			frame_start <= 1'b1;
		@(posedge core_clk);
		line_start <= 1'b0;
		frame_start <= 1'b0;
		@(posedge core_clk);
	endtask
	// wait until the fifo has emptied onto the pins
	task automatic drain;
		pix_valid <= 1'b0;
		repeat (8) @(posedge core_clk);
		do apb(1'b0, STATUS_OFFSET, 32'h0); while (rd[5] !== 1'b0);
		repeat (2) @(posedge core_clk);
	endtask
	// ====
	// scenarios
	task automatic t_regs;
		apb(1'b0, CTRL_OFFSET, 32'h0);
		check(rd, 32'(CTRL_RESET));
		apb(1'b0, STATUS_OFFSET, 32'h0);
		check(rd, 32'h10);
		apb(1'b0, 12'h008, 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, UNMAPPED_READ);
		apb(1'b1, 12'h7fc, 32'hdead_beef);
		apb(1'b0, 12'h7fc, 32'h0);
		check(rd, 32'h0000_beef);
	endtask
	task automatic t_tft;
		palw(8'h34, 16'h3434);
		palw(8'hab, 16'habab);
		palw(8'hbc, 16'hbcbc);
		palw(8'hcd, 16'hcdcd);
		apb(1'b1, CTRL_OFFSET, 32'h09);
		px(16'h1234);
		pix_valid <= 1'b0;
		apb(1'b1, CTRL_OFFSET, 32'h0b);
		px(16'habcd);
		pix_valid <= 1'b0;
		repeat (4) @(posedge core_clk);
		check(32'(u_panel.pixels.size()), 32'h2);
		check({16'h0, u_panel.pixels[0]}, 32'h3434);
		check({16'h0, u_panel.pixels[1]}, {16'h0, 5'h19, 6'h25, 5'h0b});
	endtask
	task automatic mono(input logic [31:0] ctl, input logic [7:0] pat, input int n);
		apb(1'b1, CTRL_OFFSET, ctl);
		pulse(1'b0);
		u_panel.words.delete();
		for (int i = 0; i < n; i++)
			px(pat[i] ? 16'h1f : 16'h10);
		drain;
		check(32'(u_panel.words.size()), 32'h1);
		check({24'h0, u_panel.words[0]}, {24'h0, pat});
	endtask
	task automatic t_mono;
		logic [3:0] c;
		for (int i = 0; i < 16; i++)
		begin
			c = 4'(i);
			palw(8'h10 + 8'(i), {1'b0, c, 2'b00, ~c, 1'b0, ~c});
		end
		for (int k = 0; k < 8; k++)
			palw(8'h20 + 8'(k), {1'b0, {4{k[2]}}, 2'b00, {4{k[1]}}, 1'b0, {4{k[0]}}});
		mono(32'h05, 8'h01, 4);
		mono(32'h15, 8'h85, 8);
	endtask
	task automatic t_dither;
		int per[16] = '{1, 9, 5, 15, 9, 5, 9, 2, 9, 5, 9, 15, 5, 9, 1, 1};
		int num[16] = '{0, 1, 1, 4, 3, 2, 4, 1, 5, 3, 6, 11, 4, 8, 1, 1};
		int ones;
		apb(1'b1, CTRL_OFFSET, 32'h05);
		for (int c = 0; c < 16; c++)
		begin
			u_panel.words.delete();
			pulse(1'b1);
			for (int i = 0; i < 4 * per[c]; i++)
				px(16'h10 + 16'(c));
			drain;
			ones = 0;
			foreach (u_panel.words[i])
				ones += $countones(u_panel.words[i]);
			check(32'(u_panel.words.size()), 32'(per[c]));
			check(32'(ones), 32'(4 * num[c]));
		end
	endtask
	task automatic t_color;
		logic [7:0] ex;
		int s;
		apb(1'b1, CTRL_OFFSET, 32'h01);
		pulse(1'b0);
		u_panel.words.delete();
		seen_stall = 1'b0;
		for (int i = 0; i < 48; i++)
			px(16'h20 + 16'(i % 8));
		drain;
		check({31'h0, seen_stall}, 32'h1);
		check(rd, 32'h10);
		check(32'(u_panel.words.size()), 32'd18);
		for (int w = 0; w < 18; w++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				s = 8 * w + b;
				ex[7 - b] = 1'((s / 3 % 8) >> (s % 3));
			end
			check({24'h0, u_panel.words[w]}, {24'h0, ex});
		end
	endtask
	// ====
	// main sequence
	initial
	begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pix_valid = 1'b0;
		pix_data = 16'h0;
		line_start = 1'b0;
		frame_start = 1'b0;
		seen_stall = 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_tft;
		t_mono;
		t_dither;
		t_color;
		conclude;
	end
	// watchdog
	initial
	begin
		#400000;
		err_total++;
		conclude;
	end
endmodule
bind lcd_pixel_path lcd_pixel_path_checker u_chk (.core_clk(core_clk), .resetn(resetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready),
	.tft_valid(tft_valid), .tft_red(tft_red), .panel_data_pins(panel_data_pins),
	.panel_strobe(panel_strobe));
`default_nettype wire
